// ==== sewg_write_guard.sv ====
/*
  Power-up state, serial command engine and nonvolatile write guard
  of a 512 x 8 serial EEPROM with a supervisory reset output.
  Assumes host pins are synchronous to i_sys_clk and SCK is far slower.
*/
`timescale 1ns/1ps
`default_nettype none

module sewg_write_guard #(
  parameter int unsigned PURST_CYCLES = sewg_pkg::PURST_CYC,
  parameter int unsigned WC_CYCLES    = sewg_pkg::WC_CYC
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_reset_n,
  input  wire logic       i_cs_n,
  input  wire logic       i_sck,
  input  wire logic       i_si,
  input  wire logic       i_wp_n,
  input  wire logic       i_flag_set,
  output logic            o_so,
  output logic            o_so_oe,
  output logic            o_reset_out,
  output logic            o_wel,
  output logic            o_wip,
  output logic            o_flag,
  output logic            o_standby,
  output logic [1:0]      o_bl,
  output logic [1:0]      o_wd
);

  // ----------------------------------------------------------------
  // limits and storage
  // ----------------------------------------------------------------
  localparam logic [sewg_pkg::RST_W-1:0] RST_LIM =
    sewg_pkg::RST_W'(PURST_CYCLES - 1);
  localparam logic [sewg_pkg::WC_W-1:0]  WC_LIM  =
    sewg_pkg::WC_W'(WC_CYCLES - 1);

  sewg_pkg::sewg_state_s st_r;
  sewg_pkg::sewg_state_s st_nxt;
  logic [7:0]            mem [512];
  logic                  cs_fall;
  logic                  cs_rise;
  logic                  sck_rise;
  logic                  sck_fall;
  logic [7:0]            shin_n;
  logic [8:0]            rd_addr;
  logic [7:0]            mem_q;
  logic [7:0]            sr_val;
  logic                  is_read;
  logic                  is_write;
  logic                  prot_w;
  logic                  wc_done;
  logic                  commit;

  assign cs_fall  = st_r.cs_prev & ~i_cs_n;
  assign cs_rise  = ~st_r.cs_prev & i_cs_n;
  assign sck_rise = ~st_r.sck_prev & i_sck;
  assign sck_fall = st_r.sck_prev & ~i_sck;
  assign shin_n   = {st_r.shin[6:0], i_si};
  assign is_read  = (st_r.opcode[7:4] == sewg_pkg::OP_MEM_HI) &&
                    (st_r.opcode[2:0] == sewg_pkg::OP_READ_LO);
  assign is_write = (st_r.opcode[7:4] == sewg_pkg::OP_MEM_HI) &&
                    (st_r.opcode[2:0] == sewg_pkg::OP_WRITE_LO);
  assign rd_addr  = (st_r.byte_cnt == 2'h1) ?
                    {st_r.opcode[sewg_pkg::OP_A8_POS], shin_n} : st_r.addr;
  assign mem_q    = mem[rd_addr];
  assign sr_val   = {2'h0, st_r.wd, st_r.bl, st_r.write_enable_latch, st_r.write_in_progress};
  assign wc_done  = st_r.write_in_progress && (st_r.wc_cnt == WC_LIM);
  assign commit   = wc_done && !st_r.sr_pend;

  always_comb begin
    unique case (st_r.bl)
      sewg_pkg::BL_NONE:     prot_w = 1'b0;
      sewg_pkg::BL_TOP_QTR:  prot_w = (st_r.addr[8:7] == 2'h3);
      sewg_pkg::BL_TOP_HALF: prot_w = st_r.addr[8];
      default:               prot_w = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt          = st_r;
    st_nxt.cs_prev  = i_cs_n;
    st_nxt.sck_prev = i_sck;

    if (st_r.rst_out) begin
      if (st_r.rst_cnt == RST_LIM) begin
        st_nxt.rst_out = 1'b0;
      end else begin
        st_nxt.rst_cnt = st_r.rst_cnt + 1'b1;
      end
    end

    if (st_r.phase == sewg_pkg::SEWG_STANDBY) begin
      if (cs_fall) begin
        st_nxt.phase    = sewg_pkg::SEWG_ACTIVE;
        st_nxt.bit_cnt  = 3'h0;
        st_nxt.byte_cnt = 2'h0;
        st_nxt.out_en   = 1'b0;
      end
    end else if (cs_rise) begin
      st_nxt.phase  = sewg_pkg::SEWG_STANDBY;
      st_nxt.out_en = 1'b0;
      st_nxt.so_oe  = 1'b0;
      if (st_r.bit_cnt == 3'h0 && !st_r.write_in_progress) begin
        if (st_r.opcode == sewg_pkg::OP_SET_WE && st_r.byte_cnt == 2'h1) begin
          st_nxt.write_enable_latch = 1'b1;
        end
        if (st_r.opcode == sewg_pkg::OP_CLR_WE && st_r.byte_cnt == 2'h1) begin
          st_nxt.write_enable_latch = 1'b0;
        end
        if (st_r.opcode == sewg_pkg::OP_WR_SR && st_r.byte_cnt == 2'h2 &&
            st_r.write_enable_latch && i_wp_n) begin
          st_nxt.write_in_progress     = 1'b1;
          st_nxt.wc_cnt  = '0;
          st_nxt.sr_pend = 1'b1;
          st_nxt.pend_bl = st_r.shin[sewg_pkg::SR_BL_LSB +: 2];
          st_nxt.pend_wd = st_r.shin[sewg_pkg::SR_WD_LSB +: 2];
        end
        if (is_write && st_r.byte_cnt == 2'h3 && st_r.write_enable_latch && i_wp_n &&
            !prot_w) begin
          st_nxt.write_in_progress     = 1'b1;
          st_nxt.wc_cnt  = '0;
          st_nxt.sr_pend = 1'b0;
        end
      end
    end else if (sck_rise) begin
      st_nxt.shin    = shin_n;
      st_nxt.bit_cnt = st_r.bit_cnt + 1'b1;
      if (st_r.bit_cnt == 3'h7) begin
        if (st_r.byte_cnt != 2'h3) begin
          st_nxt.byte_cnt = st_r.byte_cnt + 1'b1;
        end
        if (st_r.byte_cnt == 2'h0) begin
          st_nxt.opcode = shin_n;
          if (shin_n == sewg_pkg::OP_RD_SR) begin
            st_nxt.shout  = sr_val;
            st_nxt.out_en = 1'b1;
          end
        end else if (st_r.byte_cnt == 2'h1) begin
          if (is_read || is_write) begin
            st_nxt.addr = rd_addr;
            st_nxt.idx  = shin_n[3:0];
          end
          if (is_write && !st_r.write_in_progress) begin
            st_nxt.mask = '0;
          end
          if (is_read && !st_r.write_in_progress) begin
            st_nxt.shout  = mem_q;
            st_nxt.out_en = 1'b1;
            st_nxt.addr   = rd_addr + 1'b1;
          end
        end
        if (st_r.opcode == sewg_pkg::OP_RD_SR) begin
          st_nxt.shout = sr_val;
        end
        if (st_r.byte_cnt != 2'h0 && st_r.byte_cnt != 2'h1) begin
          if (is_read && !st_r.write_in_progress) begin
            st_nxt.shout = mem_q;
            st_nxt.addr  = st_r.addr + 1'b1;
          end
          // page buffer frozen while a cycle is pending
          if (is_write && !st_r.write_in_progress) begin
            st_nxt.page[st_r.idx] = shin_n;
            st_nxt.mask[st_r.idx] = 1'b1;
            st_nxt.idx            = st_r.idx + 1'b1;
          end
        end
      end
    end else if (sck_fall && st_r.out_en) begin
      st_nxt.so    = st_r.shout[7];
      st_nxt.so_oe = 1'b1;
      st_nxt.shout = {st_r.shout[6:0], 1'b0};
    end

    if (st_r.write_in_progress) begin
      if (wc_done) begin
        st_nxt.write_in_progress = 1'b0;
        st_nxt.write_enable_latch = 1'b0;
        if (st_r.sr_pend) begin
          st_nxt.bl = st_r.pend_bl;
          st_nxt.wd = st_r.pend_wd;
        end
      end else begin
        st_nxt.wc_cnt = st_r.wc_cnt + 1'b1;
      end
    end

    if (!i_wp_n) begin
      st_nxt.write_enable_latch = 1'b0;
    end
    if (i_flag_set) begin
      st_nxt.flag = 1'b1;
    end
    st_nxt.standby = (st_nxt.phase == sewg_pkg::SEWG_STANDBY) && !st_nxt.write_in_progress;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      st_r         <= '0;
      st_r.wd      <= sewg_pkg::WD_RST;
      st_r.bl      <= sewg_pkg::BL_RST;
      st_r.standby <= 1'b1;
      st_r.rst_out <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // array takes the page only at cycle end
  always_ff @(posedge i_sys_clk) begin
    for (int i = 0; i < 16; i++) begin
      if (commit && st_r.mask[i]) begin
        mem[{st_r.addr[8:4], 4'(i)}] <= st_r.page[i];
      end
    end
  end

  assign o_so        = st_r.so;
  assign o_so_oe     = st_r.so_oe;
  assign o_reset_out = st_r.rst_out;
  assign o_wel       = st_r.write_enable_latch;
  assign o_wip       = st_r.write_in_progress;
  assign o_flag      = st_r.flag;
  assign o_standby   = st_r.standby;
  assign o_bl        = st_r.bl;
  assign o_wd        = st_r.wd;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);

  a_standby_powerup: assert property ($rose(i_reset_n) |-> o_standby)
    else $error("not in standby after reset");
  a_ignore_until_fall: assert property (
    st_r.phase == sewg_pkg::SEWG_STANDBY && !cs_fall
    |=> st_r.phase == sewg_pkg::SEWG_STANDBY)
    else $error("selected without falling select");
  a_so_hiz_reset: assert property ($rose(i_reset_n) |-> !o_so_oe)
    else $error("serial output driven after reset");
  a_wel_reset_clear: assert property ($rose(i_reset_n) |-> !o_wel)
    else $error("latch set after reset");
  a_flag_reset_clear: assert property ($rose(i_reset_n) |-> !o_flag)
    else $error("flag set after reset");
  a_reset_out_hold: assert property ($rose(i_reset_n) |-> o_reset_out[*8])
    else $error("reset output released early");
  a_start_needs_wel: assert property ($rose(o_wip) |-> $past(o_wel))
    else $error("write started with latch clear");
  a_start_at_count: assert property (
    $rose(o_wip) |-> $past(cs_rise) && $past(st_r.bit_cnt) == 3'h0)
    else $error("write started off boundary");
  a_guard_refuse: assert property (
    $rose(o_wip) && !st_r.sr_pend |-> !$past(prot_w))
    else $error("write into guarded region");
  a_wp_blocks_start: assert property (!i_wp_n |=> !$rose(o_wip))
    else $error("write started with protect pin low");
  a_wc_bounded: assert property (o_wip |-> st_r.wc_cnt <= WC_LIM)
    else $error("write cycle too long");
  a_wel_clr_done: assert property ($fell(o_wip) |-> !o_wel)
    else $error("latch kept after write");
  a_wel_clr_pin: assert property (!i_wp_n |=> !o_wel)
    else $error("latch kept with pin low");
  a_busy_whole_cycle: assert property (o_wip && !wc_done |=> o_wip)
    else $error("busy dropped before cycle end");
  a_abandon_off_count: assert property (
    st_r.phase == sewg_pkg::SEWG_ACTIVE && cs_rise && st_r.bit_cnt != 3'h0
    |=> !$rose(o_wip))
    else $error("write started from partial byte");

  c_array_write: cover property ($rose(o_wip) && !st_r.sr_pend);
  c_status_write: cover property ($rose(o_wip) && st_r.sr_pend);
  c_reset_release: cover property ($fell(o_reset_out));
  c_set_latch: cover property ($rose(o_wel));

endmodule // sewg_write_guard

`default_nettype wire

// ==== sewg_pkg.sv ====
/*
  Shared constants and state layout of the serial EEPROM write guard.
  Assumes a 200 MHz system clock and host serial pins already
  synchronous to it.
*/
`default_nettype none

package sewg_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ     = 200;
  localparam int unsigned T_PURST_MS  = 100;
  localparam int unsigned T_WC_MS     = 10;
  localparam int unsigned PURST_CYC   = T_PURST_MS * 1000 * CLK_MHZ;
  localparam int unsigned WC_CYC      = T_WC_MS * 1000 * CLK_MHZ;
  localparam int unsigned RST_W       = 25;
  localparam int unsigned WC_W        = 21;

  // ----------------------------------------------------------------
  // instructions
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_SET_WE    = 8'h06;
  localparam logic [7:0] OP_CLR_WE    = 8'h04;
  localparam logic [7:0] OP_RD_SR     = 8'h05;
  localparam logic [7:0] OP_WR_SR     = 8'h01;
  localparam logic [3:0] OP_MEM_HI    = 4'h0;
  localparam logic [2:0] OP_READ_LO   = 3'h3;
  localparam logic [2:0] OP_WRITE_LO  = 3'h2;
  localparam int unsigned OP_A8_POS   = 3;

  // ----------------------------------------------------------------
  // status layout and reset values
  // ----------------------------------------------------------------
  localparam int unsigned SR_WIP_POS  = 0;
  localparam int unsigned SR_WEL_POS  = 1;
  localparam int unsigned SR_BL_LSB   = 2;
  localparam int unsigned SR_WD_LSB   = 4;
  localparam logic [1:0] WD_RST       = 2'h3;
  localparam logic [1:0] BL_RST       = 2'h0;
  localparam logic [1:0] BL_NONE      = 2'h0;
  localparam logic [1:0] BL_TOP_QTR   = 2'h1;
  localparam logic [1:0] BL_TOP_HALF  = 2'h2;

  typedef enum logic [0:0] {
    SEWG_STANDBY = 1'b0,
    SEWG_ACTIVE  = 1'b1
  } sewg_phase_e;

  typedef struct packed {
    sewg_phase_e       phase;
    logic              cs_prev;
    logic              sck_prev;
    logic [2:0]        bit_cnt;
    logic [1:0]        byte_cnt;
    logic [7:0]        shin;
    logic [7:0]        opcode;
    logic [8:0]        addr;
    logic [3:0]        idx;
    logic [7:0]        shout;
    logic              out_en;
    logic              so;
    logic              so_oe;
    logic              write_enable_latch;
    logic              write_in_progress;
    logic [1:0]        bl;
    logic [1:0]        wd;
    logic              flag;
    logic              standby;
    logic              rst_out;
    logic [RST_W-1:0]  rst_cnt;
    logic [WC_W-1:0]   wc_cnt;
    logic              sr_pend;
    logic [1:0]        pend_bl;
    logic [1:0]        pend_wd;
    logic [15:0][7:0]  page;
    logic [15:0]       mask;
  } sewg_state_s;

endpackage

`default_nettype wire

// ==== sewg_host_model.sv ====
/*
  Host side of the serial bus: select, serial clock and data in,
  mode 0, MSB first, two system clocks per serial half period.
  Assumes callers start a frame at a rising edge or between edges.
*/
`timescale 1ns/1ps
`default_nettype none

module sewg_host_model (
  input  wire logic i_clk,
  input  wire logic i_so,
  output var logic  o_cs_n,
  output var logic  o_sck,
  output var logic  o_si,
  output var logic [7:0] o_rx
);

  // ----------------------------------------------------------------
  // idle levels
  // ----------------------------------------------------------------
  // select low from time zero: no falling edge seen at release
  initial begin
    o_cs_n = 1'b0;
    o_sck  = 1'b0;
    o_si   = 1'b0;
    o_rx   = 8'h00;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  // ----------------------------------------------------------------
  // one framed transfer
  // ----------------------------------------------------------------
  // select falls before an instruction when open_edge set
  // select rises one serial half period after the last falling serial clock
  task automatic frame(input logic [31:0] bits, input int nbits,
                       input bit open_edge);
    @(posedge i_clk);
    if (open_edge) begin
      o_cs_n <= 1'b1;
      tick(2);
    end
    o_cs_n <= 1'b0;
    tick(2);
    for (int i = nbits - 1; i >= 0; i--) begin
      o_si <= bits[i];
      tick(2);
      o_sck <= 1'b1;
      // host samples serial output at its own rising clock edge
      o_rx  <= {o_rx[6:0], i_so};
      tick(2);
      o_sck <= 1'b0;
    end
    tick(2);
    o_cs_n <= 1'b1;
    // released data line: inverse of last value
    o_si   <= ~o_si;
    tick(2);
  endtask

endmodule // sewg_host_model

`default_nettype wire

// ==== tb_top.sv ====
/*
  Self-checking bench of the write guard with shortened counts.
  Assumes the host model in its own file and the design package.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top;

  // ----------------------------------------------------------------
  // setup
  // ----------------------------------------------------------------
  localparam int unsigned PURST = 16;
  localparam int unsigned WC    = 100;
  localparam int          LIMIT = 6000;

  logic       i_sys_clk, i_reset_n, i_wp_n, i_flag_set;
  logic       cs_n, sck, si, so, so_oe, reset_out;
  logic       write_enable_latch, write_in_progress, flag, standby;
  logic [1:0] bl, wd;
  logic [7:0] rx;
  int         num_errors, total_checks, cycles, cnt;

  sewg_host_model i_host (.i_clk(i_sys_clk), .i_so(so), .o_cs_n(cs_n),
                          .o_sck(sck), .o_si(si), .o_rx(rx));

  sewg_write_guard #(.PURST_CYCLES(PURST), .WC_CYCLES(WC)) i_dut (
    .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_cs_n(cs_n),
    .i_sck(sck), .i_si(si), .i_wp_n(i_wp_n), .i_flag_set(i_flag_set),
    .o_so(so), .o_so_oe(so_oe), .o_reset_out(reset_out), .o_wel(write_enable_latch),
    .o_wip(write_in_progress), .o_flag(flag), .o_standby(standby), .o_bl(bl),
    .o_wd(wd));

  always #2.5 i_sys_clk = ~i_sys_clk;

  always @(posedge i_sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      num_errors++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                       input string msg);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t %s seen %0h exp %0h", $time, msg, seen,
               exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // high-time count of busy or reset output, seen at falling edges
  task automatic count_high(input bit busy, input int lim);
    cnt = 0;
    @(negedge i_sys_clk);
    while ((busy ? write_in_progress : reset_out) === 1'b1 && cnt < lim) begin
      @(negedge i_sys_clk);
      cnt++;
    end
  endtask

  function automatic logic [31:0] wr_word(input logic [8:0] a,
                                          input logic [7:0] d);
    return {8'h00, sewg_pkg::OP_MEM_HI, a[8], sewg_pkg::OP_WRITE_LO,
            a[7:0], d};
  endfunction

  // host sets the latch before a write
  task automatic set_we();
    i_host.frame({24'h000000, sewg_pkg::OP_SET_WE}, 8, 1'b1);
    @(negedge i_sys_clk);
    check(write_enable_latch, 8'h01, "latch set");
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_power_up();
    @(negedge i_sys_clk);
    check(standby, 8'h01, "standby");
    check(so_oe, 8'h00, "so driven");
    check(write_enable_latch, 8'h00, "latch");
    check(flag, 8'h00, "flag");
    count_high(1'b0, PURST + 8);
    check(8'(cnt >= PURST - 2 && cnt <= PURST + 1), 8'h01, "rst");
    i_host.frame({24'h000000, sewg_pkg::OP_SET_WE}, 8, 1'b0);
    @(negedge i_sys_clk);
    check(write_enable_latch, 8'h00, "no edge");
    check(so_oe, 8'h00, "so idle");
  endtask

  task automatic t_writes();
    i_host.frame(wr_word(9'h005, 8'h5A), 24, 1'b1);
    @(negedge i_sys_clk);
    check(write_in_progress, 8'h00, "write w/o latch");
    set_we();
    i_host.frame({wr_word(9'h005, 8'h5A), 4'hA}, 28, 1'b1);
    @(negedge i_sys_clk);
    check(write_in_progress, 8'h00, "partial byte");
    set_we();
    i_host.frame(wr_word(9'h00F, 8'hA5), 24, 1'b1);
    count_high(1'b1, WC + 8);
    check(8'(cnt >= WC - 3 && cnt <= WC), 8'h01, "cycle len");
    check(8'(cnt > 0), 8'h01, "busy seen");
    check(write_enable_latch, 8'h00, "latch after");
    check(standby, 8'h01, "idle after");
  endtask

  task automatic t_guard();
    set_we();
    i_host.frame({16'h0000, sewg_pkg::OP_WR_SR, 8'h08}, 16, 1'b1);
    count_high(1'b1, WC + 8);
    check(8'(bl), 8'h02, "guard bits");
    check(8'(wd), 8'h00, "wd bits");
    set_we();
    i_host.frame(wr_word(9'h100, 8'h11), 24, 1'b1);
    @(negedge i_sys_clk);
    check(write_in_progress, 8'h00, "guarded write");
  endtask

  task automatic t_protect_pin();
    set_we();
    @(posedge i_sys_clk);
    i_wp_n <= 1'b0;
    repeat (2) @(negedge i_sys_clk);
    check(write_enable_latch, 8'h00, "pin clears");
    i_host.frame({24'h000000, sewg_pkg::OP_SET_WE}, 8, 1'b1);
    i_host.frame({16'h0000, sewg_pkg::OP_WR_SR, 8'h00}, 16, 1'b1);
    @(negedge i_sys_clk);
    check(write_in_progress, 8'h00, "pin blocks");
    check(8'(bl), 8'h02, "bits kept");
    @(posedge i_sys_clk);
    i_wp_n <= 1'b1;
  endtask

  // status read while a write cycle runs
  task automatic t_status_read();
    set_we();
    i_host.frame(wr_word(9'h006, 8'h3C), 24, 1'b1);
    i_host.frame({16'h0000, sewg_pkg::OP_RD_SR, 8'h00}, 16, 1'b1);
    check(rx, 8'h0B, "status in cycle");
    @(negedge i_sys_clk);
    check(so_oe, 8'h00, "so released");
    count_high(1'b1, WC + 8);
    check(write_in_progress, 8'h00, "busy ends");
    check(write_enable_latch, 8'h00, "latch after read");
  endtask

  task automatic t_flag_reset();
    @(posedge i_sys_clk);
    i_flag_set <= 1'b1;
    @(posedge i_sys_clk);
    i_flag_set <= 1'b0;
    repeat (2) @(negedge i_sys_clk);
    check(flag, 8'h01, "flag set");
    @(posedge i_sys_clk);
    i_reset_n <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    @(negedge i_sys_clk);
    check(flag, 8'h00, "flag cleared");
    check(reset_out, 8'h01, "rst again");
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    i_sys_clk    = 1'b0;
    i_reset_n    = 1'b0;
    i_wp_n       = 1'b1;
    i_flag_set   = 1'b0;
    num_errors   = 0;
    total_checks = 0;
    cycles       = 0;
    repeat (2) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    t_power_up();
    t_writes();
    t_guard();
    t_protect_pin();
    t_status_read();
    t_flag_reset();
    tally_and_finish();
  end

endmodule // tb_top

`default_nettype wire
